// file: hw/pwmult_pkg.sv
/*
  Constants for the PWM update-lockout and A/D trigger block: register
  offsets, field positions, widths, reset values and time base modes.
  Assumes one 20 MHz peripheral clock and a byte-wide register port.
*/
package pwmult_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 8;
  localparam int TB_W    = 12;
  localparam int DUTY_W  = 14;
  localparam int NDUTY   = 4;
  localparam int PRESC_W = 6;
  localparam int POST_W  = 4;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [4:0] OFS_TB_CTL0   = 5'h00;
  localparam logic [4:0] OFS_TB_CTL1   = 5'h01;
  localparam logic [4:0] OFS_CNT_LO    = 5'h02;
  localparam logic [4:0] OFS_CNT_HI    = 5'h03;
  localparam logic [4:0] OFS_PER_LO    = 5'h04;
  localparam logic [4:0] OFS_PER_HI    = 5'h05;
  localparam logic [4:0] OFS_CMP_LO    = 5'h06;
  localparam logic [4:0] OFS_CMP_HI    = 5'h07;
  localparam logic [4:0] OFS_OUT_MODE  = 5'h08;
  localparam logic [4:0] OFS_UPD_TRIG  = 5'h09;
  localparam logic [4:0] OFS_DEADTIME  = 5'h0A;
  localparam logic [4:0] OFS_FAULT_CFG = 5'h0B;
  localparam logic [4:0] OFS_OVD_SEL   = 5'h0C;
  localparam logic [4:0] OFS_OVD_STATE = 5'h0D;
  localparam logic [4:0] OFS_DUTY_BASE = 5'h0E;  // duty n low at base+2n
  localparam logic [4:0] OFS_DUTY_LAST = 5'h15;

  // ****************************************
  // fields
  // ****************************************
  localparam int TB0_MODE_LSB  = 0;   // [1:0] time base mode
  localparam int TB0_CKPS_LSB  = 2;   // [3:2] input prescale 1/4/16/64
  localparam int TB1_EN_BIT    = 7;
  localparam int TB1_DIR_BIT   = 6;   // read-only count direction
  localparam int UPD_POST_LSB  = 4;   // [7:4] trigger postscale field
  localparam int UPD_DIRSEL_BIT = 3;
  localparam int UPD_LOCK_BIT  = 1;
  localparam int UPD_OVERRIDE_SYNC_BIT = 0;
  localparam logic [7:0] UPD_MASK      = 8'hFB;
  localparam logic [7:0] OUT_MODE_MASK = 8'h7F;
  localparam logic [7:0] TB1_MASK      = 8'hC0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [11:0] RST_TB   = 12'h000;
  localparam logic [13:0] RST_DUTY = 14'h0000;

  typedef enum logic [1:0] {
    PWMULT_FREE_RUN,
    PWMULT_SINGLE_SHOT,
    PWMULT_UP_DOWN,
    PWMULT_UP_DOWN_DBL
  } pwmult_mode_t;

endpackage : pwmult_pkg

// file: hw/pwmult_top.sv
/*
  PWM time base with double-buffered duty and period registers, update
  lockout, and the postscaled special event trigger toward the A/D.
  Assumes the register master is on sys_clk and never issues read and
  write together; adcEnable comes from the converter on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pwmult_top (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [7:0]  regRdData,
  input  wire logic        adcEnable,
  output logic             adcTrigger,
  output logic             adcStart,
  output logic      [11:0] timebaseCount,
  output logic      [11:0] activePeriod,
  output logic      [13:0] activeDuty0,
  output logic      [13:0] activeDuty1,
  output logic      [13:0] activeDuty2,
  output logic      [13:0] activeDuty3
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [5:0] prescLimit(input logic [1:0] ckps);
    unique case (ckps)
      2'b00:   prescLimit = 6'h00;
      2'b01:   prescLimit = 6'h03;
      2'b10:   prescLimit = 6'h0F;
      default: prescLimit = 6'h3F;
    endcase
  endfunction : prescLimit

  function automatic logic hits(input logic [4:0] a, input logic [4:0] o);
    hits = (a == o);
  endfunction : hits

  // ****************************************
  // state
  // ****************************************
  logic [7:0]  tbCtl0_reg,   tbCtl0_next;
  logic        tbEn_reg,     tbEn_next;
  logic        countDown_reg, countDown_next;
  logic [7:0]  updCtl_reg,   updCtl_next;
  logic [7:0]  outMode_reg,  outMode_next;
  logic [7:0]  deadtime_reg, deadtime_next;
  logic [7:0]  faultCfg_reg, faultCfg_next;
  logic [7:0]  ovdSel_reg,   ovdSel_next;
  logic [7:0]  ovdState_reg, ovdState_next;
  logic [11:0] count_reg,    count_next;
  logic [11:0] perBuf_reg,   perBuf_next;
  logic [11:0] perAct_reg,   perAct_next;
  logic [11:0] cmp_reg,      cmp_next;
  logic [13:0] dutyBuf_reg [4];
  logic [13:0] dutyBuf_next [4];
  logic [13:0] dutyAct_reg [4];
  logic [13:0] dutyAct_next [4];
  logic [5:0]  presc_reg,    presc_next;
  logic [3:0]  post_reg,     post_next;
  logic        lockPrev_reg, lockPrev_next;
  logic        trig_reg,     trig_next;
  logic        start_reg,    start_next;
  logic [7:0]  rd_reg,       rd_next;

  pwmult_pkg::pwmult_mode_t mode;
  logic        lockout;
  logic        tick;
  logic        atTop;
  logic        atBottom;
  logic        boundary;
  logic        transfer;
  logic        dirOk;
  logic        match;
  logic        cmpWrite;
  logic [4:0]  dutyOfs;

  assign mode = pwmult_pkg::pwmult_mode_t'(
                  tbCtl0_reg[pwmult_pkg::TB0_MODE_LSB +: 2]);
  assign lockout = updCtl_reg[pwmult_pkg::UPD_LOCK_BIT];
  assign tick = tbEn_reg && (presc_reg ==
                prescLimit(tbCtl0_reg[pwmult_pkg::TB0_CKPS_LSB +: 2]));
  assign atTop = (count_reg >= perAct_reg);
  assign atBottom = (count_reg == pwmult_pkg::RST_TB);

  // ****************************************
  // time base and buffer transfer
  // ****************************************
  always_comb
  begin
    boundary = 1'b0;
    unique case (mode)
      pwmult_pkg::PWMULT_FREE_RUN,
      pwmult_pkg::PWMULT_SINGLE_SHOT:
        boundary = tick && atTop;
      pwmult_pkg::PWMULT_UP_DOWN:
        boundary = tick && countDown_reg && atBottom;
      pwmult_pkg::PWMULT_UP_DOWN_DBL:
        boundary = tick && ((countDown_reg && atBottom) ||
                            (!countDown_reg && atTop));
    endcase
    // unlocked: copy at period edge, or at once when lockout drops
    transfer = !lockout && (boundary || lockPrev_reg);
  end

  always_comb
  begin
    presc_next = tick ? 6'h00 :
                 (tbEn_reg ? presc_reg + 6'h01 : 6'h00);
    count_next = count_reg;
    countDown_next = countDown_reg;
    tbEn_next = tbEn_reg;
    if (tick)
    begin
      unique case (mode)
        pwmult_pkg::PWMULT_FREE_RUN:
          count_next = atTop ? pwmult_pkg::RST_TB : count_reg + 12'h001;
        pwmult_pkg::PWMULT_SINGLE_SHOT:
        begin
          if (atTop)
          begin
            count_next = pwmult_pkg::RST_TB;
            tbEn_next = 1'b0;
          end
          else
            count_next = count_reg + 12'h001;
        end
        pwmult_pkg::PWMULT_UP_DOWN,
        pwmult_pkg::PWMULT_UP_DOWN_DBL:
        begin
          if (!countDown_reg && atTop)
          begin
            countDown_next = 1'b1;
            count_next = count_reg - 12'h001;
          end
          else if (countDown_reg && atBottom)
          begin
            countDown_next = 1'b0;
            count_next = count_reg + 12'h001;
          end
          else
            count_next = countDown_reg ? count_reg - 12'h001
                                       : count_reg + 12'h001;
        end
      endcase
    end
    if (mode == pwmult_pkg::PWMULT_FREE_RUN ||
        mode == pwmult_pkg::PWMULT_SINGLE_SHOT)
      countDown_next = 1'b0;
    // a software write to the count or enable overrides the counter
    if (regWrEn && hits(regAddr, pwmult_pkg::OFS_CNT_LO))
      count_next = {count_reg[11:8], regWrData};
    if (regWrEn && hits(regAddr, pwmult_pkg::OFS_CNT_HI))
      count_next = {regWrData[3:0], count_reg[7:0]};
    if (regWrEn && hits(regAddr, pwmult_pkg::OFS_TB_CTL1))
      tbEn_next = regWrData[pwmult_pkg::TB1_EN_BIT];
    perAct_next = transfer ? perBuf_reg : perAct_reg;
    for (int i = 0; i < pwmult_pkg::NDUTY; i++)
      dutyAct_next[i] = transfer ? dutyBuf_reg[i] : dutyAct_reg[i];
    lockPrev_next = lockout;
    // remembered so the falling edge of lockout forces one transfer
  end

  // ****************************************
  // special event trigger
  // ****************************************
  always_comb
  begin
    // direction qualifies only in the up/down modes
    if (mode == pwmult_pkg::PWMULT_UP_DOWN ||
        mode == pwmult_pkg::PWMULT_UP_DOWN_DBL)
      dirOk = updCtl_reg[pwmult_pkg::UPD_DIRSEL_BIT] == countDown_reg;
    else
      dirOk = 1'b1;
    // sampled on tick so each count value matches once
    match = tick && (count_reg == cmp_reg) && dirOk;
    cmpWrite = regWrEn && (hits(regAddr, pwmult_pkg::OFS_CMP_LO) ||
                           hits(regAddr, pwmult_pkg::OFS_CMP_HI));
    trig_next = 1'b0;
    post_next = post_reg;
    if (cmpWrite)
      post_next = 4'h0;
    else if (match)
    begin
      if (post_reg == updCtl_reg[pwmult_pkg::UPD_POST_LSB +: 4])
      begin
        trig_next = 1'b1;
        post_next = 4'h0;
      end
      else
        post_next = post_reg + 4'h1;
    end
    // the trigger leaves the time base flag alone; start needs the A/D on
    start_next = trig_next && adcEnable;
  end

  // ****************************************
  // register writes
  // ****************************************
  always_comb
  begin
    tbCtl0_next = tbCtl0_reg;
    updCtl_next = updCtl_reg;
    outMode_next = outMode_reg;
    deadtime_next = deadtime_reg;
    faultCfg_next = faultCfg_reg;
    ovdSel_next = ovdSel_reg;
    ovdState_next = ovdState_reg;
    perBuf_next = perBuf_reg;
    cmp_next = cmp_reg;
    dutyOfs = regAddr - pwmult_pkg::OFS_DUTY_BASE;
    for (int i = 0; i < pwmult_pkg::NDUTY; i++)
      dutyBuf_next[i] = dutyBuf_reg[i];
    if (regWrEn)
    begin
      unique case (regAddr)
        pwmult_pkg::OFS_TB_CTL0:   tbCtl0_next = regWrData;
        pwmult_pkg::OFS_PER_LO:    perBuf_next[7:0] = regWrData;
        pwmult_pkg::OFS_PER_HI:    perBuf_next[11:8] = regWrData[3:0];
        pwmult_pkg::OFS_CMP_LO:    cmp_next[7:0] = regWrData;
        pwmult_pkg::OFS_CMP_HI:    cmp_next[11:8] = regWrData[3:0];
        pwmult_pkg::OFS_OUT_MODE:
          outMode_next = regWrData & pwmult_pkg::OUT_MODE_MASK;
        pwmult_pkg::OFS_UPD_TRIG:
          updCtl_next = regWrData & pwmult_pkg::UPD_MASK;
        pwmult_pkg::OFS_DEADTIME:  deadtime_next = regWrData;
        pwmult_pkg::OFS_FAULT_CFG: faultCfg_next = regWrData;
        pwmult_pkg::OFS_OVD_SEL:   ovdSel_next = regWrData;
        pwmult_pkg::OFS_OVD_STATE: ovdState_next = regWrData;
        default:
        begin
          if (regAddr >= pwmult_pkg::OFS_DUTY_BASE &&
              regAddr <= pwmult_pkg::OFS_DUTY_LAST)
          begin
            if (dutyOfs[0])
              dutyBuf_next[dutyOfs[2:1]][13:8] = regWrData[5:0];
            else
              dutyBuf_next[dutyOfs[2:1]][7:0] = regWrData;
          end
        end
      endcase
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always_comb
  begin
    rd_next = rd_reg;
    if (regRdEn)
    begin
      rd_next = 8'h00;
      unique case (regAddr)
        pwmult_pkg::OFS_TB_CTL0:   rd_next = tbCtl0_reg;
        pwmult_pkg::OFS_TB_CTL1:
          rd_next = {tbEn_reg, countDown_reg, 6'h00};
        pwmult_pkg::OFS_CNT_LO:    rd_next = count_reg[7:0];
        pwmult_pkg::OFS_CNT_HI:    rd_next = {4'h0, count_reg[11:8]};
        pwmult_pkg::OFS_PER_LO:    rd_next = perBuf_reg[7:0];
        pwmult_pkg::OFS_PER_HI:    rd_next = {4'h0, perBuf_reg[11:8]};
        pwmult_pkg::OFS_CMP_LO:    rd_next = cmp_reg[7:0];
        pwmult_pkg::OFS_CMP_HI:    rd_next = {4'h0, cmp_reg[11:8]};
        pwmult_pkg::OFS_OUT_MODE:  rd_next = outMode_reg;
        pwmult_pkg::OFS_UPD_TRIG:  rd_next = updCtl_reg;
        pwmult_pkg::OFS_DEADTIME:  rd_next = deadtime_reg;
        pwmult_pkg::OFS_FAULT_CFG: rd_next = faultCfg_reg;
        pwmult_pkg::OFS_OVD_SEL:   rd_next = ovdSel_reg;
        pwmult_pkg::OFS_OVD_STATE: rd_next = ovdState_reg;
        default:
        begin
          if (regAddr >= pwmult_pkg::OFS_DUTY_BASE &&
              regAddr <= pwmult_pkg::OFS_DUTY_LAST)
            rd_next = dutyOfs[0] ?
                      {2'b00, dutyBuf_reg[dutyOfs[2:1]][13:8]} :
                      dutyBuf_reg[dutyOfs[2:1]][7:0];
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      tbCtl0_reg    <= pwmult_pkg::RST_BYTE;
      tbEn_reg      <= 1'b0;
      countDown_reg <= 1'b0;
      updCtl_reg    <= pwmult_pkg::RST_BYTE;
      outMode_reg   <= pwmult_pkg::RST_BYTE;
      deadtime_reg  <= pwmult_pkg::RST_BYTE;
      faultCfg_reg  <= pwmult_pkg::RST_BYTE;
      ovdSel_reg    <= pwmult_pkg::RST_BYTE;
      ovdState_reg  <= pwmult_pkg::RST_BYTE;
      count_reg     <= pwmult_pkg::RST_TB;
      perBuf_reg    <= pwmult_pkg::RST_TB;
      perAct_reg    <= pwmult_pkg::RST_TB;
      cmp_reg       <= pwmult_pkg::RST_TB;
      for (int i = 0; i < pwmult_pkg::NDUTY; i++)
      begin
        dutyBuf_reg[i] <= pwmult_pkg::RST_DUTY;
        dutyAct_reg[i] <= pwmult_pkg::RST_DUTY;
      end
      presc_reg     <= 6'h00;
      post_reg      <= 4'h0;
      lockPrev_reg  <= 1'b0;
      trig_reg      <= 1'b0;
      start_reg     <= 1'b0;
      rd_reg        <= pwmult_pkg::RST_BYTE;
    end
    else
    begin
      tbCtl0_reg    <= tbCtl0_next;
      tbEn_reg      <= tbEn_next;
      countDown_reg <= countDown_next;
      updCtl_reg    <= updCtl_next;
      outMode_reg   <= outMode_next;
      deadtime_reg  <= deadtime_next;
      faultCfg_reg  <= faultCfg_next;
      ovdSel_reg    <= ovdSel_next;
      ovdState_reg  <= ovdState_next;
      count_reg     <= count_next;
      perBuf_reg    <= perBuf_next;
      perAct_reg    <= perAct_next;
      cmp_reg       <= cmp_next;
      for (int i = 0; i < pwmult_pkg::NDUTY; i++)
      begin
        dutyBuf_reg[i] <= dutyBuf_next[i];
        dutyAct_reg[i] <= dutyAct_next[i];
      end
      presc_reg     <= presc_next;
      post_reg      <= post_next;
      lockPrev_reg  <= lockPrev_next;
      trig_reg      <= trig_next;
      start_reg     <= start_next;
      rd_reg        <= rd_next;
    end
  end

  assign regRdData     = rd_reg;
  assign adcTrigger    = trig_reg;
  assign adcStart      = start_reg;
  assign timebaseCount = count_reg;
  assign activePeriod  = perAct_reg;
  assign activeDuty0   = dutyAct_reg[0];
  assign activeDuty1   = dutyAct_reg[1];
  assign activeDuty2   = dutyAct_reg[2];
  assign activeDuty3   = dutyAct_reg[3];

endmodule : pwmult_top

`default_nettype wire

// file: test/pwmult_properties.sv
/*
  Port-level checker for the PWM update lockout and A/D trigger block.
  Assumes one clock domain; it shadows the control writes it needs.
*/
`timescale 1ns/1ps
`default_nettype none

module pwmult_properties (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [4:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData,
  input wire logic        adcEnable,
  input wire logic        adcTrigger,
  input wire logic        adcStart,
  input wire logic [11:0] timebaseCount,
  input wire logic [11:0] activePeriod,
  input wire logic [13:0] activeDuty3
);
  // ******************
  // register shadows
  // ******************
  logic [11:0] cmp_reg, cmp_next, per_reg, per_next;
  logic [13:0] d3_reg, d3_next;
  logic [7:0]  upd_reg, upd_next, tb0_reg, tb0_next;
  wire         lockOn = upd_reg[1];
  wire         udFast = tb0_reg[1] && (tb0_reg[3:2] == 2'h0);

  always_comb
  begin
    {cmp_next, per_next, d3_next, upd_next, tb0_next} =
      {cmp_reg, per_reg, d3_reg, upd_reg, tb0_reg};
    if (regWrEn)
    begin
      case (regAddr)
        pwmult_pkg::OFS_TB_CTL0:  tb0_next = regWrData;
        pwmult_pkg::OFS_PER_LO:   per_next[7:0] = regWrData;
        pwmult_pkg::OFS_PER_HI:   per_next[11:8] = regWrData[3:0];
        pwmult_pkg::OFS_CMP_LO:   cmp_next[7:0] = regWrData;
        pwmult_pkg::OFS_CMP_HI:   cmp_next[11:8] = regWrData[3:0];
        pwmult_pkg::OFS_UPD_TRIG: upd_next = regWrData;
        5'h14:                    d3_next[7:0] = regWrData;
        5'h15:                    d3_next[13:8] = regWrData[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
    {cmp_reg, per_reg, d3_reg, upd_reg, tb0_reg} <= sys_rst ? '0 :
      {cmp_next, per_next, d3_next, upd_next, tb0_next};

  // ******************
  // properties
  // ******************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence unlockSeq;
    lockOn ##1 !lockOn;
  endsequence
  sequence cmpWrite;
    regWrEn && (regAddr == 5'h06 || regAddr == 5'h07);
  endsequence

  trig_match_a:
    assert property (adcTrigger |-> $past(timebaseCount) == $past(cmp_reg))
    else $error("trigger without compare match");
  start_gate_a:
    assert property (adcStart == (adcTrigger && $past(adcEnable)))
    else $error("start not gated by converter enable");
  pulse_single_a:
    assert property (adcTrigger && upd_reg[7:4] != 4'h0 |=> !adcTrigger)
    else $error("postscaled trigger repeated");
  lock_hold_a:
    assert property (lockOn |=> $stable(activePeriod) && $stable(activeDuty3))
    else $error("active value moved while locked");
  unlock_load_a:
    assert property (unlockSeq |=> activePeriod == $past(per_reg)
      && activeDuty3 == $past(d3_reg))
    else $error("unlock did not load buffers");
  per_copy_a:
    assert property ($changed(activePeriod) |->
      activePeriod == $past(per_reg) && !$past(lockOn))
    else $error("active period not taken from buffer");
  cmp_quiet_a:
    assert property (cmpWrite |=> !adcTrigger)
    else $error("trigger after compare write");
  rd_unmapped_a:
    assert property (regRdEn && regAddr > 5'h15 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  rd_upper_a:
    assert property (regRdEn && (regAddr == 5'h05 || regAddr == 5'h07)
      |=> regRdData[7:4] == 4'h0)
    else $error("unused period or compare bits set");
  rd_duty_hi_a:
    assert property (regRdEn && regAddr >= 5'h0E && regAddr <= 5'h15
      && regAddr[0] |=> regRdData[7:6] == 2'h0)
    else $error("unused duty bits set");
  dir_qual_a:
    assert property (adcTrigger && $past(udFast) && !$past(regWrEn)
      && $past(cmp_reg) != 12'h000 && $past(cmp_reg) < $past(activePeriod)
      |-> ($past(upd_reg[3]) ? timebaseCount < $past(timebaseCount)
                             : timebaseCount > $past(timebaseCount)))
    else $error("trigger in wrong count phase");
endmodule : pwmult_properties

`default_nettype wire

// file: test/pwmult_adc_model.sv
/*
  Conversion start side of the A/D converter: random enable level,
  counts started conversions. Assumes the same clock as the block.
*/
`timescale 1ns/1ps
`default_nettype none

module pwmult_adc_model (
  input  wire logic sys_clk,
  input  wire logic adcTrigger,
  input  wire logic adcStart,
  output logic      adcEnable,
  output int        starts,
  output int        expStarts
);
  int   seed = 3;
  logic enPrev = 1'b0;

  // enable wanders so pulses are seen both used and ignored
  always @(posedge sys_clk)
  begin
    adcEnable <= 1'($random(seed));
    enPrev <= adcEnable;
    if (adcStart === 1'b1) starts <= starts + 1;
    if (adcTrigger === 1'b1 && enPrev) expStarts <= expStarts + 1;
  end
endmodule : pwmult_adc_model

`default_nettype wire

// file: test/pwmult_tb.sv
/*
  Self-checking bench for the PWM update lockout and A/D trigger block.
  Assumes a 20 MHz clock and the byte register port of the design.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        sys_clk, sys_rst, regWrEn, regRdEn, adcEnable;
  logic        adcTrigger, adcStart;
  logic [4:0]  regAddr;
  logic [7:0]  regWrData, regRdData, d;
  logic [11:0] timebaseCount, activePeriod;
  logic [13:0] activeDuty0, activeDuty1, activeDuty2, activeDuty3;
  logic [13:0] dutyExp [4];
  int          errTotal, compares, seed, starts, expStarts, cnt, n;
  int          posts [$] = '{0, 1, 3, 15};

  pwmult_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .adcEnable(adcEnable),
    .adcTrigger(adcTrigger), .adcStart(adcStart),
    .timebaseCount(timebaseCount), .activePeriod(activePeriod),
    .activeDuty0(activeDuty0), .activeDuty1(activeDuty1),
    .activeDuty2(activeDuty2), .activeDuty3(activeDuty3));

  pwmult_adc_model adc (.sys_clk(sys_clk), .adcTrigger(adcTrigger),
    .adcStart(adcStart), .adcEnable(adcEnable), .starts(starts),
    .expStarts(expStarts));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ******************
  // helpers
  // ******************
  function automatic logic [7:0] maskOf(input logic [4:0] a);
    case (a)
      5'h05, 5'h07:               maskOf = 8'h0F;
      5'h08:                      maskOf = 8'h7F;
      5'h09:                      maskOf = 8'hFB;
      5'h0F, 5'h11, 5'h13, 5'h15: maskOf = 8'h3F;
      default:                    maskOf = (a > 5'h15) ? 8'h00 : 8'hFF;
    endcase
  endfunction : maskOf

  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      errTotal++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chkVal

  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
    chkVal({8'h00, got}, {8'h00, exp});
  endtask : chkReg

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rdChk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(negedge sys_clk);
    chkReg(regRdData, exp);
  endtask : rdChk

  task automatic countTrig(input int len);
    cnt = 0;
    repeat (len)
    begin
      @(posedge sys_clk);
      #1;
      if (adcTrigger === 1'b1) cnt++;
    end
  endtask : countTrig

  task automatic doReset();
    sys_rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask : doReset

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // ******************
  // tests
  // ******************
  initial
  begin
    sys_rst = 1'b1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 5'h00;
    regWrData = 8'h00;
    seed = 3;
    doReset();
    for (int a = 0; a < 24; a++) rdChk(5'(a), 8'h00);
    $display("reset value test done");
    for (int a = 4; a < 24; a++)
    begin
      d = 8'($random(seed));
      wr(5'(a), d);
      rdChk(5'(a), d & maskOf(5'(a)));
    end
    $display("register access test done");
    @(posedge sys_clk);
    doReset();
    wr(5'h04, 8'h0F);
    wr(5'h01, 8'h80);
    repeat (40) @(posedge sys_clk);
    chkVal(16'(activePeriod), 16'h000F);
    wr(5'h09, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      dutyExp[i] = 14'($random(seed));
      wr(5'(14 + 2 * i), dutyExp[i][7:0]);
      wr(5'(15 + 2 * i), {2'b00, dutyExp[i][13:8]});
    end
    wr(5'h04, 8'h13);
    repeat (60) @(posedge sys_clk);
    chkVal(16'(activePeriod), 16'h000F);
    chkVal(16'(activeDuty1), 16'h0000);
    wr(5'h09, 8'h00);
    repeat (2) @(negedge sys_clk);
    chkVal(16'(activePeriod), 16'h0013);
    chkVal(16'(activeDuty0), 16'(dutyExp[0]));
    chkVal(16'(activeDuty1), 16'(dutyExp[1]));
    chkVal(16'(activeDuty2), 16'(dutyExp[2]));
    chkVal(16'(activeDuty3), 16'(dutyExp[3]));
    $display("update lockout test done");
    // 20 cycles a period, so each window holds 2n+1 matches
    foreach (posts[j])
    begin
      n = posts[j];
      wr(5'h09, 8'((n << 4) | 8));
      wr(5'h07, 8'h00);
      wr(5'h06, 8'h05);
      @(posedge sys_clk);
      countTrig((2 * n + 1) * 20);
      chkVal(16'(cnt), 16'((2 * n + 1) / (n + 1)));
    end
    chkVal(16'(starts), 16'(expStarts));
    $display("postscaler test done");
    wr(5'h00, 8'h02);
    for (int k = 0; k < 2; k++)
    begin
      wr(5'h09, 8'(k << 3));
      wr(5'h06, 8'h05);
      countTrig(200);
      chkVal(16'(cnt != 0), 16'h0001);
    end
    $display("count direction test done");
    // single shot: one period from zero, then the enable drops
    wr(5'h00, 8'h01);
    wr(5'h02, 8'h00);
    repeat (30) @(posedge sys_clk);
    rdChk(5'h01, 8'h00);
    // double-update up/down with prescale 4, down phase selected
    wr(5'h00, 8'h07);
    wr(5'h01, 8'h80);
    wr(5'h09, 8'h08);
    wr(5'h06, 8'h05);
    countTrig(400);
    chkVal(16'(cnt != 0), 16'h0001);
    $display("mode test done");
    print_verdict();
  end

  initial
  begin
    #(50 * 10000);
    errTotal++;
    print_verdict();
  end
endmodule : testbench

bind pwmult_top pwmult_properties u_props (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .adcEnable(adcEnable), .adcTrigger(adcTrigger), .adcStart(adcStart),
  .timebaseCount(timebaseCount), .activePeriod(activePeriod),
  .activeDuty3(activeDuty3));

`default_nettype wire
